// File: logic/ppc_defines.vh
// Register map, reset values and widths of the port pin control block
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

`define PPC_ADDR_W          16
`define PPC_ADDR_PORT0      16'hff00
`define PPC_ADDR_PORT1      16'hff01
`define PPC_ADDR_PORT2      16'hff02
`define PPC_ADDR_PORT3      16'hff03
`define PPC_ADDR_PORT8      16'hff08
`define PPC_ADDR_PORT9      16'hff09
`define PPC_ADDR_DIR0       16'hff20
`define PPC_ADDR_DIR1       16'hff21
`define PPC_ADDR_DIR2       16'hff22
`define PPC_ADDR_DIR3       16'hff23
`define PPC_ADDR_DIR8       16'hff28
`define PPC_ADDR_DIR9       16'hff29
`define PPC_ADDR_PULL_UP_SELECT_PORT0       16'hff30
`define PPC_ADDR_PULL_UP_SELECT_PORT1       16'hff31
`define PPC_ADDR_PULL_UP_SELECT_PORT2       16'hff32
`define PPC_ADDR_PULL_UP_SELECT_PORT3       16'hff33
`define PPC_ADDR_PULL_UP_SELECT_PORT8       16'hff38
`define PPC_ADDR_PULL_UP_SELECT_PORT9       16'hff39
`define PPC_ADDR_SEG8       16'hff58
`define PPC_ADDR_SEG9       16'hff59

`define PPC_DIR_RESET       8'hff
`define PPC_PUB_RESET       8'h00
`define PPC_SEG_RESET       8'h00
`define PPC_LATCH_RESET     8'h00

`define PPC_MASK_PORT0      8'h0f
`define PPC_MASK_PORT1      8'h03
`define PPC_MASK_PORT2      8'h07
`define PPC_MASK_PORT3      8'h0f
`define PPC_MASK_PORT8      8'h1f
`define PPC_MASK_PORT9      8'h3f

`endif

// File: logic/ppc_port_bank.v
// One I/O port: direction, output latch, pull-up select, optional segment select
`include "ppc_defines.vh"
`default_nettype none

module ppc_port_bank #(
    parameter [7:0] PIN_MASK = 8'hff,
    parameter       HAS_SEG  = 0
) (
    input  wire       i_core_clk,
    input  wire       i_reset,
    input  wire       i_wr_latch,
    input  wire       i_wr_dir,
    input  wire       i_wr_pub,
    input  wire       i_wr_seg,
    input  wire [7:0] i_wdata,
    input  wire [7:0] i_pin_in,
    input  wire [7:0] i_seg_out,
    output reg  [7:0] o_latch_q,
    output reg  [7:0] o_dir_q,
    output reg  [7:0] o_pub_q,
    output reg  [7:0] o_seg_q,
    output wire [7:0] o_port_rdata,
    output wire [7:0] o_pin_out,
    output wire [7:0] o_pin_oe,
    output wire [7:0] o_pull_up_en
);

    // ************************************************************
    // Control registers
    // ************************************************************
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_dir_q   <= `PPC_DIR_RESET & PIN_MASK;
            o_pub_q   <= `PPC_PUB_RESET;
            o_seg_q   <= `PPC_SEG_RESET;
            o_latch_q <= `PPC_LATCH_RESET;
        end else begin
            // Latch loads in either mode and holds until the next write
            if (i_wr_latch) begin
                o_latch_q <= i_wdata & PIN_MASK;
            end
            if (i_wr_dir) begin
                o_dir_q <= i_wdata & PIN_MASK;
            end
            if (i_wr_pub) begin
                o_pub_q <= i_wdata & PIN_MASK;
            end
            if (i_wr_seg && (HAS_SEG != 0)) begin
                o_seg_q <= i_wdata & PIN_MASK;
            end
        end
    end

    // ************************************************************
    // Pin side
    // ************************************************************
    // Buffer on when direction is 0; segment function overrides both
    assign o_pin_oe  = ((~o_dir_q) | o_seg_q) & PIN_MASK;
    assign o_pin_out = ((o_seg_q & i_seg_out) | (~o_seg_q & o_latch_q)) & PIN_MASK;
    // Pull-up follows select bit only in input mode; segment mode does not cut it
    assign o_pull_up_en = o_pub_q & o_dir_q & PIN_MASK;

    // Output bits read the latch, input bits read the pin
    assign o_port_rdata = ((~o_dir_q & o_latch_q) | (o_dir_q & i_pin_in)) & PIN_MASK;

endmodule

`default_nettype wire

// File: logic/ppc_port_pin_control.v
// Top of the port pin control block: CPU register access and six ports
`include "ppc_defines.vh"
`default_nettype none

module ppc_port_pin_control (
    input  wire        i_core_clk,
    input  wire        i_reset,
    input  wire [15:0] i_addr,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire        i_bit_op,
    input  wire [2:0]  i_bit_sel,
    input  wire        i_bit_val,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata,
    output wire        o_hit,
    input  wire [7:0]  i_port0_pin,
    input  wire [7:0]  i_port1_pin,
    input  wire [7:0]  i_port2_pin,
    input  wire [7:0]  i_port3_pin,
    input  wire [7:0]  i_port8_pin,
    input  wire [7:0]  i_port9_pin,
    input  wire [7:0]  i_seg8_out,
    input  wire [7:0]  i_seg9_out,
    output wire [47:0] o_pin_out,
    output wire [47:0] o_pin_oe,
    output wire [47:0] o_pull_up_en
);

    // ************************************************************
    // Address decode
    // ************************************************************
    localparam integer NP = 6;

    reg  [NP-1:0] sel_latch;
    reg  [NP-1:0] sel_dir;
    reg  [NP-1:0] sel_pub;
    reg  [1:0]    sel_seg;
    wire [47:0]   latch_v;
    wire [47:0]   dir_v;
    wire [47:0]   pub_v;
    wire [47:0]   seg_v;
    wire [47:0]   prd_v;
    wire [47:0]   pin_v;
    wire [15:0]   segsrc_v;
    reg  [7:0]    cur_val;
    reg  [7:0]    wr_byte;
    wire          wr_eff;

    assign pin_v    = {i_port9_pin, i_port8_pin, i_port3_pin, i_port2_pin, i_port1_pin, i_port0_pin};
    assign segsrc_v = {i_seg9_out, i_seg8_out};

    always @* begin
        sel_latch = 6'h00;
        sel_dir   = 6'h00;
        sel_pub   = 6'h00;
        sel_seg   = 2'h0;
        if (i_addr == `PPC_ADDR_PORT0) begin
            sel_latch[0] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PORT1) begin
            sel_latch[1] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PORT2) begin
            sel_latch[2] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PORT3) begin
            sel_latch[3] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PORT8) begin
            sel_latch[4] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PORT9) begin
            sel_latch[5] = 1'b1;
        end else if (i_addr == `PPC_ADDR_DIR0) begin
            sel_dir[0] = 1'b1;
        end else if (i_addr == `PPC_ADDR_DIR1) begin
            sel_dir[1] = 1'b1;
        end else if (i_addr == `PPC_ADDR_DIR2) begin
            sel_dir[2] = 1'b1;
        end else if (i_addr == `PPC_ADDR_DIR3) begin
            sel_dir[3] = 1'b1;
        end else if (i_addr == `PPC_ADDR_DIR8) begin
            sel_dir[4] = 1'b1;
        end else if (i_addr == `PPC_ADDR_DIR9) begin
            sel_dir[5] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PULL_UP_SELECT_PORT0) begin
            sel_pub[0] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PULL_UP_SELECT_PORT1) begin
            sel_pub[1] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PULL_UP_SELECT_PORT2) begin
            sel_pub[2] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PULL_UP_SELECT_PORT3) begin
            sel_pub[3] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PULL_UP_SELECT_PORT8) begin
            sel_pub[4] = 1'b1;
        end else if (i_addr == `PPC_ADDR_PULL_UP_SELECT_PORT9) begin
            sel_pub[5] = 1'b1;
        end else if (i_addr == `PPC_ADDR_SEG8) begin
            sel_seg[0] = 1'b1;
        end else if (i_addr == `PPC_ADDR_SEG9) begin
            sel_seg[1] = 1'b1;
        end
    end

    assign o_hit = (|sel_latch) | (|sel_dir) | (|sel_pub) | (|sel_seg);

    // ************************************************************
    // Read path
    // ************************************************************
    // Segment selects are write-only and read as zero
    always @* begin
        cur_val = 8'h00;
        if (|sel_latch) begin
            cur_val = byte_of(prd_v, sel_latch);
        end else if (|sel_dir) begin
            // Unimplemented direction bits read as ones, matching their fixed reset state
            cur_val = byte_of(dir_v, sel_dir) | ~byte_of(mask_v(1'b0), sel_dir);
        end else if (|sel_pub) begin
            cur_val = byte_of(pub_v, sel_pub);
        end
    end

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= cur_val;
        end
    end

    // ************************************************************
    // Write path
    // ************************************************************
    // A bit operation merges one bit into the byte as read, so input-mode
    // latch bits pick up the pin level: the documented hazard, kept on purpose
    always @* begin
        wr_byte = i_wdata;
        if (i_bit_op) begin
            wr_byte = cur_val;
            wr_byte[i_bit_sel] = i_bit_val;
        end
    end

    // Bit operations on segment selects are refused
    assign wr_eff = i_wr & ~(i_bit_op & (|sel_seg));

    // ************************************************************
    // Helpers
    // ************************************************************
    function [47:0] mask_v;
        input dummy;
        begin
            mask_v = {`PPC_MASK_PORT9, `PPC_MASK_PORT8, `PPC_MASK_PORT3,
                      `PPC_MASK_PORT2, `PPC_MASK_PORT1, `PPC_MASK_PORT0};
        end
    endfunction

    function [7:0] byte_of;
        input [47:0] vec;
        input [5:0]  sel;
        integer k;
        begin
            byte_of = 8'h00;
            for (k = 0; k < NP; k = k + 1) begin
                if (sel[k]) begin
                    byte_of = vec[k*8 +: 8];
                end
            end
        end
    endfunction

    // ************************************************************
    // Port instances
    // ************************************************************
    ppc_port_bank #(.PIN_MASK(`PPC_MASK_PORT0), .HAS_SEG(0)) u_port0 (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .i_wr_latch   (wr_eff & sel_latch[0]),
        .i_wr_dir     (wr_eff & sel_dir[0]),
        .i_wr_pub     (wr_eff & sel_pub[0]),
        .i_wr_seg     (1'b0),
        .i_wdata      (wr_byte),
        .i_pin_in     (pin_v[7:0]),
        .i_seg_out    (8'h00),
        .o_latch_q    (latch_v[7:0]),
        .o_dir_q      (dir_v[7:0]),
        .o_pub_q      (pub_v[7:0]),
        .o_seg_q      (seg_v[7:0]),
        .o_port_rdata (prd_v[7:0]),
        .o_pin_out    (o_pin_out[7:0]),
        .o_pin_oe     (o_pin_oe[7:0]),
        .o_pull_up_en (o_pull_up_en[7:0])
    );

    ppc_port_bank #(.PIN_MASK(`PPC_MASK_PORT1), .HAS_SEG(0)) u_port1 (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .i_wr_latch   (wr_eff & sel_latch[1]),
        .i_wr_dir     (wr_eff & sel_dir[1]),
        .i_wr_pub     (wr_eff & sel_pub[1]),
        .i_wr_seg     (1'b0),
        .i_wdata      (wr_byte),
        .i_pin_in     (pin_v[15:8]),
        .i_seg_out    (8'h00),
        .o_latch_q    (latch_v[15:8]),
        .o_dir_q      (dir_v[15:8]),
        .o_pub_q      (pub_v[15:8]),
        .o_seg_q      (seg_v[15:8]),
        .o_port_rdata (prd_v[15:8]),
        .o_pin_out    (o_pin_out[15:8]),
        .o_pin_oe     (o_pin_oe[15:8]),
        .o_pull_up_en (o_pull_up_en[15:8])
    );

    ppc_port_bank #(.PIN_MASK(`PPC_MASK_PORT2), .HAS_SEG(0)) u_port2 (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .i_wr_latch   (wr_eff & sel_latch[2]),
        .i_wr_dir     (wr_eff & sel_dir[2]),
        .i_wr_pub     (wr_eff & sel_pub[2]),
        .i_wr_seg     (1'b0),
        .i_wdata      (wr_byte),
        .i_pin_in     (pin_v[23:16]),
        .i_seg_out    (8'h00),
        .o_latch_q    (latch_v[23:16]),
        .o_dir_q      (dir_v[23:16]),
        .o_pub_q      (pub_v[23:16]),
        .o_seg_q      (seg_v[23:16]),
        .o_port_rdata (prd_v[23:16]),
        .o_pin_out    (o_pin_out[23:16]),
        .o_pin_oe     (o_pin_oe[23:16]),
        .o_pull_up_en (o_pull_up_en[23:16])
    );

    ppc_port_bank #(.PIN_MASK(`PPC_MASK_PORT3), .HAS_SEG(0)) u_port3 (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .i_wr_latch   (wr_eff & sel_latch[3]),
        .i_wr_dir     (wr_eff & sel_dir[3]),
        .i_wr_pub     (wr_eff & sel_pub[3]),
        .i_wr_seg     (1'b0),
        .i_wdata      (wr_byte),
        .i_pin_in     (pin_v[31:24]),
        .i_seg_out    (8'h00),
        .o_latch_q    (latch_v[31:24]),
        .o_dir_q      (dir_v[31:24]),
        .o_pub_q      (pub_v[31:24]),
        .o_seg_q      (seg_v[31:24]),
        .o_port_rdata (prd_v[31:24]),
        .o_pin_out    (o_pin_out[31:24]),
        .o_pin_oe     (o_pin_oe[31:24]),
        .o_pull_up_en (o_pull_up_en[31:24])
    );

    ppc_port_bank #(.PIN_MASK(`PPC_MASK_PORT8), .HAS_SEG(1)) u_port8 (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .i_wr_latch   (wr_eff & sel_latch[4]),
        .i_wr_dir     (wr_eff & sel_dir[4]),
        .i_wr_pub     (wr_eff & sel_pub[4]),
        .i_wr_seg     (wr_eff & sel_seg[0]),
        .i_wdata      (wr_byte),
        .i_pin_in     (pin_v[39:32]),
        .i_seg_out    (segsrc_v[7:0]),
        .o_latch_q    (latch_v[39:32]),
        .o_dir_q      (dir_v[39:32]),
        .o_pub_q      (pub_v[39:32]),
        .o_seg_q      (seg_v[39:32]),
        .o_port_rdata (prd_v[39:32]),
        .o_pin_out    (o_pin_out[39:32]),
        .o_pin_oe     (o_pin_oe[39:32]),
        .o_pull_up_en (o_pull_up_en[39:32])
    );

    ppc_port_bank #(.PIN_MASK(`PPC_MASK_PORT9), .HAS_SEG(1)) u_port9 (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .i_wr_latch   (wr_eff & sel_latch[5]),
        .i_wr_dir     (wr_eff & sel_dir[5]),
        .i_wr_pub     (wr_eff & sel_pub[5]),
        .i_wr_seg     (wr_eff & sel_seg[1]),
        .i_wdata      (wr_byte),
        .i_pin_in     (pin_v[47:40]),
        .i_seg_out    (segsrc_v[15:8]),
        .o_latch_q    (latch_v[47:40]),
        .o_dir_q      (dir_v[47:40]),
        .o_pub_q      (pub_v[47:40]),
        .o_seg_q      (seg_v[47:40]),
        .o_port_rdata (prd_v[47:40]),
        .o_pin_out    (o_pin_out[47:40]),
        .o_pin_oe     (o_pin_oe[47:40]),
        .o_pull_up_en (o_pull_up_en[47:40])
    );

endmodule

`default_nettype wire

// File: bench/ppc_port_pin_control_props.sv
// Concurrent checks on the ports of the port pin control block
`default_nettype none
module ppc_props (
    input wire logic        i_core_clk,
    input wire logic        i_reset,
    input wire logic [15:0] i_addr,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_bit_op,
    input wire logic [7:0]  i_wdata,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_hit,
    input wire logic [7:0]  i_port1_pin,
    input wire logic [7:0]  i_seg8_out,
    input wire logic [47:0] o_pin_out,
    input wire logic [47:0] o_pin_oe,
    input wire logic [47:0] o_pull_up_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Properties
    // ****************
    wire logic byte_wr;
    assign byte_wr = i_wr && !i_bit_op;
    default clocking dc @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    property p_dir_oe;
        byte_wr && i_addr == 16'hff20 |=> o_pin_oe[3:0] == ~$past(i_wdata[3:0]);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("port0 enable does not follow direction");
    property p_latch_out;
        byte_wr && i_addr == 16'hff00 |=> ((o_pin_out[3:0] ^ $past(i_wdata[3:0])) & o_pin_oe[3:0]) == 4'h0;
    endproperty
    a_latch_out: assert property (p_latch_out) else $error("driven pin differs from written latch");
    property p_in_hold;
        i_wr && i_addr == 16'hff00 |=> $stable(o_pin_oe[3:0]);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("latch write changed the enables");
    property p_no_pu_out;
        (o_pull_up_en[31:0] & o_pin_oe[31:0]) == 32'h0;
    endproperty
    a_no_pu_out: assert property (p_no_pu_out) else $error("pull-up on a driven pin");
    property p_pu_sel;
        byte_wr && i_addr == 16'hff39 |=> (o_pull_up_en[45:40] & ~$past(i_wdata[5:0])) == 6'h0;
    endproperty
    a_pu_sel: assert property (p_pu_sel) else $error("pull-up without select bit");
    property p_rd_pin;
        i_rd && i_addr == 16'hff01 |=> o_rdata[7:2] == 6'h0 &&
            ((o_rdata[1:0] ^ $past(i_port1_pin[1:0])) & ~$past(o_pin_oe[9:8])) == 2'h0;
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("port1 read does not show pin level");
    property p_seg_rd;
        i_rd && (i_addr == 16'hff58 || i_addr == 16'hff59) |=> o_rdata == 8'h0;
    endproperty
    a_seg_rd: assert property (p_seg_rd) else $error("segment select readable");
    property p_seg_pin;
        byte_wr && i_addr == 16'hff58 |=> ((o_pin_out[36:32] ^ i_seg8_out[4:0]) & $past(i_wdata[4:0])) == 5'h0 &&
            (o_pin_oe[36:32] & $past(i_wdata[4:0])) == $past(i_wdata[4:0]);
    endproperty
    a_seg_pin: assert property (p_seg_pin) else $error("segment pin not driven by segment value");
    property p_unmapped;
        i_addr == 16'hff10 |-> !o_hit;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hit on an unmapped address");
endmodule
bind ppc_port_pin_control ppc_props u_props (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_bit_op(i_bit_op), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_hit(o_hit),
    .i_port1_pin(i_port1_pin), .i_seg8_out(i_seg8_out), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_pull_up_en(o_pull_up_en));
`default_nettype wire

// File: bench/ppc_board.sv
// Board model: resolves each package pin from device drive, pull-up and external sources
`default_nettype none
module ppc_board (
    input  wire logic        i_core_clk,
    input  wire logic [47:0] i_pin_out,
    input  wire logic [47:0] i_pin_oe,
    input  wire logic [47:0] i_pull_up_en,
    input  wire logic [47:0] i_ext_val,
    input  wire logic [47:0] i_ext_en,
    output logic      [47:0] o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [47:0] float_q = 48'h0;
    // A floating pin wanders so that a missing pull-up cannot read as a lucky constant
    always @(posedge i_core_clk)
        float_q <= ~o_level;
    always_comb
        for (int k = 0; k < 48; k++)
            o_level[k] = i_pin_oe[k] ? i_pin_out[k] : i_ext_en[k] ? i_ext_val[k] :
                         i_pull_up_en[k] ? 1'b1 : float_q[k];
endmodule
`default_nettype wire

// File: bench/ppc_port_pin_control_test.sv
// Self-checking testbench of the port pin control block
`default_nettype none
module ppc_port_pin_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [15:0] i_addr = 16'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_bit_op = 1'b0;
    logic [2:0]  i_bit_sel = 3'h0;
    logic        i_bit_val = 1'b0;
    logic [7:0]  i_wdata = 8'h0;
    logic [7:0]  i_seg8_out = 8'h15;
    logic [7:0]  i_seg9_out = 8'h2a;
    logic [47:0] ext_val = 48'h0;
    logic [47:0] ext_en = 48'h0;
    wire  [7:0]  o_rdata;
    wire         o_hit;
    wire  [47:0] o_pin_out;
    wire  [47:0] o_pin_oe;
    wire  [47:0] o_pull_up_en;
    wire  [47:0] level;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #10 i_core_clk = ~i_core_clk;
    ppc_port_pin_control uut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_bit_op(i_bit_op), .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_hit(o_hit), .i_port0_pin(level[7:0]), .i_port1_pin(level[15:8]),
        .i_port2_pin(level[23:16]), .i_port3_pin(level[31:24]), .i_port8_pin(level[39:32]),
        .i_port9_pin(level[47:40]), .i_seg8_out(i_seg8_out), .i_seg9_out(i_seg9_out),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_up_en(o_pull_up_en));
    ppc_board board (.i_core_clk(i_core_clk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_pull_up_en(o_pull_up_en), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(level));
    // ****************
    // Bus cycles and comparison
    // ****************
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic b, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        i_addr = a;
        i_wr = w;
        i_rd = !w;
        i_bit_op = b;
        i_wdata = d;
        i_bit_sel = d[2:0];
        i_bit_val = d[3];
        @(posedge i_core_clk);
        #1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_bit_op = 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b0, a, 8'h0);
        chk(o_rdata, exp);
    endtask
    task automatic end_of_test;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        logic [7:0] offs [6] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h8, 8'h9};
        chk(o_pin_oe, 48'h0);
        chk(o_pull_up_en, 48'h0);
        for (int k = 0; k < 6; k++) begin
            rdchk(16'hff20 + offs[k], 8'hff);
            rdchk(16'hff30 + offs[k], 8'h00);
        end
    endtask
    task automatic t_output;
        bus(1'b1, 1'b0, 16'hff20, 8'h00);
        bus(1'b1, 1'b0, 16'hff00, 8'h0a);
        chk(o_pin_oe[7:0], 48'h0f);
        chk(o_pin_out[3:0], 48'ha);
        rdchk(16'hff00, 8'h0a);
        bus(1'b1, 1'b0, 16'hff22, 8'h06);
        bus(1'b1, 1'b0, 16'hff02, 8'h00);
        chk(o_pin_oe[23:16], 48'h01);
        chk(o_pin_out[16], 48'h0);
    endtask
    task automatic t_input;
        ext_en[1:0] = 2'b11;
        ext_val[1:0] = 2'b01;
        bus(1'b1, 1'b0, 16'hff20, 8'h03);
        bus(1'b1, 1'b0, 16'hff00, 8'h0e);
        chk(level[1:0], 48'h1);
        rdchk(16'hff00, 8'h0d);
        ext_en[1:0] = 2'b00;
        bus(1'b1, 1'b0, 16'hff20, 8'h00);
        rdchk(16'hff00, 8'h0e);
    endtask
    task automatic t_pullup;
        bus(1'b1, 1'b0, 16'hff20, 8'h0c);
        bus(1'b1, 1'b0, 16'hff30, 8'h0f);
        chk(o_pull_up_en[3:0], 48'hc);
        rdchk(16'hff00, 8'h0e);
        rdchk(16'hff30, 8'h0f);
        bus(1'b1, 1'b0, 16'hff32, 8'hff);
        rdchk(16'hff32, 8'h07);
        bus(1'b1, 1'b1, 16'hff31, 8'h09);
        rdchk(16'hff31, 8'h02);
        bus(1'b1, 1'b0, 16'hff39, 8'hff);
        chk(o_pull_up_en[47:40], 48'h3f);
        bus(1'b1, 1'b0, 16'hff39, 8'h00);
    endtask
    task automatic t_seg;
        bus(1'b1, 1'b0, 16'hff38, 8'h01);
        bus(1'b1, 1'b0, 16'hff58, 8'hff);
        chk(o_pin_oe[39:32], 48'h1f);
        chk(o_pin_out[36:32], 48'h15);
        chk(o_pull_up_en[32], 48'h1);
        rdchk(16'hff58, 8'h00);
        bus(1'b1, 1'b1, 16'hff59, 8'h08);
        chk(o_pin_oe[40], 48'h0);
        bus(1'b1, 1'b0, 16'hff59, 8'hff);
        chk(o_pin_oe[47:40], 48'h3f);
        chk(o_pin_out[47:40], 48'h2a);
        bus(1'b1, 1'b0, 16'hff59, 8'h00);
        bus(1'b1, 1'b0, 16'hff58, 8'h00);
        chk(o_pin_oe[39:32], 48'h0);
    endtask
    task automatic t_bitop;
        bus(1'b1, 1'b0, 16'hff21, 8'h01);
        bus(1'b1, 1'b0, 16'hff01, 8'h00);
        ext_en[8] = 1'b1;
        ext_val[8] = 1'b1;
        bus(1'b1, 1'b1, 16'hff01, 8'h09);
        chk(o_pin_out[9], 48'h1);
        rdchk(16'hff01, 8'h03);
        ext_en[8] = 1'b0;
        bus(1'b1, 1'b0, 16'hff21, 8'h00);
        rdchk(16'hff01, 8'h03);
        bus(1'b1, 1'b0, 16'hff01, 8'h03 + 8'h01);
        chk(o_pin_out[9:8], 48'h0);
    endtask
    task automatic t_unmapped;
        bus(1'b1, 1'b0, 16'hff10, 8'hff);
        rdchk(16'hff10, 8'h00);
        chk(o_hit, 48'h0);
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge i_core_clk);
        #1;
        i_reset = 1'b0;
        t_reset();
        t_output();
        t_input();
        t_pullup();
        t_seg();
        t_bitop();
        t_unmapped();
        end_of_test();
    end
endmodule
`default_nettype wire
